// ---- bench/serial_burst_error_recovery_tb_top.sv ----
// self-checking bench for the burst ecc unit: registers, serial runs, modes, interrupt
`timescale 1ns/1ps
`default_nettype none
module serial_burst_error_recovery_tb_top;
   import burst_ecc_pkg::*;
   localparam logic [31:0] INV = 32'h8000_0003;
   logic        clk, arst_n, hsel, hwrite, hold, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, syn;
   logic        src_bit, src_valid, rx_bit, rx_valid, tx_bit, tx_valid, busy, irq;
   logic        stream[$];
   int          err_count, n_tests;

   burst_ecc_core dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .SRC_BIT(src_bit), .SRC_VALID(src_valid), .RX_BIT(rx_bit),
      .RX_VALID(rx_valid), .HOLD(hold), .TX_BIT(tx_bit), .TX_VALID(tx_valid), .BUSY(busy), .IRQ(irq));
   serial_far_end far (.CLK(clk), .HOLD(hold), .TX_BIT(tx_bit), .TX_VALID(tx_valid), .SRC_BIT(src_bit),
      .SRC_VALID(src_valid), .RX_BIT(rx_bit), .RX_VALID(rx_valid));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
         err_count++;
      end
   endtask
   // one single transfer; the master waits on hready with no assumed latency
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(exp, q);
   endtask
   // busy rises one edge after start, so one edge passes before polling;
   // one more edge after idle lets the far end log the last transmitted bit
   task automatic wait_idle();
      int n;
      n = 0;
      @(posedge clk);
      while (busy !== 1'b0 && n < 9000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      if (n >= 9000) begin
         err_count++;
         results();
      end
   endtask
   function automatic logic [31:0] step(logic [31:0] c, logic b, logic p32);
      logic fb;
      fb = (p32 ? c[31] : c[15]) ^ b;
      c = (c << 1) ^ (fb ? (p32 ? POLY32 : POLY16) : 32'h0);
      return c & (p32 ? MASK32 : MASK16);
   endfunction
   function automatic logic [31:0] ctl(mode_e m, logic p32, logic [1:0] sp, int nb);
      return {13'h0, 11'(nb), 2'h0, 1'b1, sp, p32, m};
   endfunction

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic run_tx(input logic p32, input logic [31:0] inv, input int nb, input logic pause);
      logic [31:0] c;
      c = p32 ? MASK32 : MASK16;
      stream.delete();
      far.got_q.delete();
      wr(OFF_INVERT, inv);
      wr(OFF_CTRL, ctl(MODE_TX, p32, 2'h0, nb));
      for (int i = 0; i < nb * 8; i++) stream.push_back(1'((i * 37 >> 2) & 1));
      far.src_q = stream;
      foreach (far.src_q[i]) c = step(c, far.src_q[i], p32);
      for (int k = (p32 ? 31 : 15); k >= 0; k--) stream.push_back(c[k] ^ inv[k]);
      if (pause) begin
         repeat (6) @(posedge clk);
         hold <= 1'b1;
         repeat (5) @(posedge clk);
         hold <= 1'b0;
      end
      wait_idle();
      chk(stream.size(), far.got_q.size());
      foreach (stream[k]) chk(stream[k], far.got_q[k]);
   endtask
   // feeds the last transmitted frame back with nf bits flipped from position at
   task automatic run_rx(input int at, input int nf);
      logic        q[$];
      logic [31:0] c;
      int          n;
      c = MASK32;
      n = stream.size() - 32;
      q = stream;
      for (int i = at; i < at + nf; i++) q[i] = ~stream[i];
      foreach (q[i]) c = step(c, q[i] ^ (i >= n ? INV[stream.size() - 1 - i] : 1'b0), 1'b1);
      syn = c;
      far.got_q.delete();
      wr(OFF_STATUS, 32'h1f);
      wr(OFF_CTRL, ctl(MODE_RX, 1'b1, 2'h0, n / 8));
      far.rx_q = q;
      wait_idle();
      rdc(OFF_SYND, c);
      rdc(OFF_STATUS, (c != 32'h0) ? 32'h3 : 32'h1);
      chk(32'h0, far.got_q.size());
   endtask
   // hardware correction stops on zero, on a trapped burst or at the step limit
   task automatic run_corr(input logic [1:0] sp);
      logic [31:0] c, st;
      logic [10:0] sm;
      int          k;
      c = syn;
      st = 32'h9;
      k = 0;
      sm = sp == 2'h0 ? SPAN5_MASK : (sp == 2'h1 ? SPAN8_MASK : SPAN11_MASK);
      // the limit state after block bits plus checkbits steps is still examined
      for (int n = 0; n <= 3 * 8 + 32 && st == 32'h9; n++) begin
         k = n;
         if (c == 32'h0) st = 32'h1;
         else if ((c & ~{21'h0, sm}) == 32'h0) st = 32'h5;
         else c = step(c, 1'b0, 1'b1);
      end
      wr(OFF_STATUS, 32'h1f);
      wr(OFF_CTRL, ctl(MODE_CORR, 1'b1, sp, 3));
      wait_idle();
      rdc(OFF_STATUS, st);
      if (st == 32'h5) rdc(OFF_LOC, {5'h00, c[10:0] & sm, 2'b00, 14'(k)});
   endtask
   task automatic refusals();
      logic [31:0] bad[4];
      bad = '{ctl(MODE_TX, 1'b0, 2'h0, 0), ctl(MODE_RX, 1'b1, 2'h0, 1025),
              ctl(MODE_CORR, 1'b0, 2'h0, 3), ctl(MODE_SEARCH, 1'b0, 2'h0, 3)};
      foreach (bad[i]) begin
         wr(OFF_STATUS, 32'h1f);
         wr(OFF_CTRL, bad[i]);
         repeat (2) @(posedge clk);
         rdc(OFF_STATUS, 32'h10);
      end
   endtask

   // ------------------------------------------------------------
   // clock, sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      arst_n = 1'b0;
      {hsel, hwrite, hold, htrans, haddr, hwdata} = '0;
      err_count = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) if (i != 6) rdc(8'(i * 4), i == 3 ? 32'hffff_ffff : 32'h0);
      chk(32'h0, {31'h0, hresp});
      wr(OFF_MASK, 32'h1);
      far.slow = 1'b1;
      run_tx(1'b0, 32'h0, 2, 1'b1);
      far.slow = 1'b0;
      chk(32'h1, {31'h0, irq});
      wr(OFF_MASK, 32'h0);
      rdc(OFF_STATUS, 32'h1);
      chk(32'h0, {31'h0, irq});
      wr(OFF_MASK, 32'h1);
      wr(OFF_STATUS, 32'h1);
      rdc(OFF_STATUS, 32'h0);
      chk(32'h0, {31'h0, irq});
      run_tx(1'b1, INV, 3, 1'b0);
      run_rx(0, 0);
      run_rx(5, 4);
      wr(OFF_CTRL, ctl(MODE_SEARCH, 1'b1, 2'h0, 3));
      wr(OFF_STEP, 32'h1);
      syn = step(syn, 1'b0, 1'b1);
      rdc(OFF_SYND, syn);
      for (int s = 0; s < 3; s++) begin
         run_rx(5, 4);
         run_corr(2'(s));
      end
      refusals();
      results();
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      results();
   end
endmodule
`default_nettype wire

// ---- bench/serial_far_end.sv ----
// serial source and sink model for the far side of the burst ecc unit
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
   input  wire logic CLK,
   input  wire logic HOLD,
   input  wire logic TX_BIT,
   input  wire logic TX_VALID,
   output logic      SRC_BIT,
   output logic      SRC_VALID,
   output logic      RX_BIT,
   output logic      RX_VALID
);
   logic src_q[$];
   logic rx_q[$];
   logic got_q[$];
   logic slow = 1'b0;
   logic gap  = 1'b0;

   // lines start idle; an unoffered line flips so a stale bit is never mistaken for data
   initial begin
      SRC_BIT   = 1'b0;
      SRC_VALID = 1'b0;
      RX_BIT    = 1'b0;
      RX_VALID  = 1'b0;
   end

   // a bit leaves its queue only at an edge where it was offered and hold was low
   always @(posedge CLK) begin
      if (SRC_VALID && !HOLD) void'(src_q.pop_front());
      if (RX_VALID && !HOLD) void'(rx_q.pop_front());
      if (TX_VALID) got_q.push_back(TX_BIT);
      gap = slow & ~gap;
      SRC_VALID <= !gap && src_q.size() > 0;
      SRC_BIT   <= (!gap && src_q.size() > 0) ? src_q[0] : ~SRC_BIT;
      RX_VALID  <= !gap && rx_q.size() > 0;
      RX_BIT    <= (!gap && rx_q.size() > 0) ? rx_q[0] : ~RX_BIT;
   end
endmodule
`default_nettype wire

// ---- core/burst_ecc_core.sv ----
// serial burst error detection and correction unit with an AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module burst_ecc_core
   import burst_ecc_pkg::*;
#(
   parameter int MAXB = MAX_BYTES
)(
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        SRC_BIT,
   input  wire logic        SRC_VALID,
   input  wire logic        RX_BIT,
   input  wire logic        RX_VALID,
   input  wire logic        HOLD,
   output logic             TX_BIT,
   output logic             TX_VALID,
   output logic             BUSY,
   output logic             IRQ
);

   typedef enum logic [1:0] {S_IDLE, S_DATA, S_CHECK, S_TRAP} state_e;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   state_e              state;
   ctrl_s               cfg;
   ctrl_s               new_cfg;
   logic [31:0]         invert;
   logic [31:0]         lfsr;
   logic [STAT_W-1:0]   status;
   logic [STAT_W-1:0]   irq_mask;
   logic [STAT_W-1:0]   ev;
   logic [STAT_W-1:0]   clr;
   logic [13:0]         cnt;
   logic [13:0]         loc;
   logic [10:0]         pattern;
   logic [5:0]          ccnt;
   logic                wr_pend;
   logic [7:0]          wr_addr;
   logic                accept;
   logic                wr;
   logic                start;
   logic                step;
   logic                refuse;
   logic [31:0]         poly;
   logic [31:0]         wmask;
   logic [5:0]          cw;
   logic [13:0]         blk_bits;
   logic [10:0]         span_mask;
   logic                take;
   logic                in_bit;
   logic                inv_bit;
   logic                last_chk;
   logic [31:0]         next_lfsr;
   logic                trapped;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // zero wait state slave, every transfer answered OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign accept    = HSEL && HTRANS[1] && HREADY;
   assign wr        = wr_pend;
   assign new_cfg   = '{len_bytes: HWDATA[18:8], span: HWDATA[4:3], poly32: HWDATA[2],
                        mode: mode_e'(HWDATA[1:0])};
   assign start     = wr && (wr_addr == OFF_CTRL) && HWDATA[CTRL_START];
   assign step      = wr && (wr_addr == OFF_STEP);
   assign clr       = (wr && (wr_addr == OFF_STATUS)) ? HWDATA[STAT_W-1:0] : '0;

   // address phase of a write is held for its data phase
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= accept && HWRITE;
         wr_addr <= HADDR[7:0];
      end
   end

   // read data is captured in the address phase so it stands in the data phase
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HRDATA <= 32'h0000_0000;
      end else if (accept && !HWRITE) begin
         case (HADDR[7:0])
            OFF_CTRL:   HRDATA <= {13'h0000, cfg.len_bytes, 3'b000, cfg.span, cfg.poly32, cfg.mode};
            OFF_STATUS: HRDATA <= {23'h000000, BUSY, 3'b000, status};
            OFF_MASK:   HRDATA <= {27'h0000000, irq_mask};
            OFF_SYND:   HRDATA <= lfsr;
            OFF_INVERT: HRDATA <= invert;
            OFF_LOC:    HRDATA <= {5'h00, pattern, 2'b00, loc};
            default:    HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // control registers, a start in a busy unit leaves the settings alone
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg      <= CTRL_RST;
         invert   <= INVERT_RST;
         irq_mask <= MASK_RST;
      end else if (wr) begin
         if (wr_addr == OFF_CTRL && state == S_IDLE) cfg <= new_cfg;   // RL6
         if (wr_addr == OFF_INVERT) invert <= HWDATA;                   // RL9
         if (wr_addr == OFF_MASK) irq_mask <= HWDATA[STAT_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // generator selection
   // ----------------------------------------------------------------
   // the register shared by both codes; the 16-bit code uses the low half only
   always_comb begin
      if (cfg.poly32) begin
         poly  = POLY32;   // RL3
         wmask = MASK32;
         cw    = CW32;
      end else begin
         poly  = POLY16;   // RL1
         wmask = MASK16;
         cw    = CW16;
      end
      case (cfg.span)
         2'h0:    span_mask = SPAN5_MASK;   // RL4
         2'h1:    span_mask = SPAN8_MASK;
         default: span_mask = SPAN11_MASK;
      endcase
   end

   assign blk_bits = {cfg.len_bytes[10:0], 3'b000};

   // one galois step of the selected generator
   function automatic logic [31:0] lfsr_step(input logic [31:0] r, input logic b, input logic wide,
                                             input logic [31:0] p, input logic [31:0] m);
      logic fb;
      fb = b ^ (wide ? r[31] : r[15]);
      return ({r[30:0], 1'b0} ^ (fb ? p : 32'h0000_0000)) & m;
   endfunction

   // ----------------------------------------------------------------
   // serial datapath
   // ----------------------------------------------------------------
   // data bits come from the transmit source or the receive port, never both
   always_comb begin
      inv_bit = invert[ccnt[4:0]];
      in_bit  = (cfg.mode == MODE_TX) ? SRC_BIT : RX_BIT;   // RL8
      case (state)
         S_DATA:  take = !HOLD && ((cfg.mode == MODE_TX) ? SRC_VALID : RX_VALID);   // RL7
         S_CHECK: take = !HOLD && ((cfg.mode == MODE_TX) || RX_VALID);
         S_TRAP:  take = !HOLD;
         default: take = 1'b0;
      endcase
      if (state == S_CHECK && cfg.mode == MODE_RX)
         next_lfsr = lfsr_step(lfsr, RX_BIT ^ inv_bit, cfg.poly32, poly, wmask);   // RL9
      else
         next_lfsr = lfsr_step(lfsr, 1'b0, cfg.poly32, poly, wmask);
   end

   assign last_chk = (state == S_CHECK) && take && (ccnt == 6'h00);
   // burst trapped once every syndrome bit above the span is clear
   assign trapped  = (lfsr != 32'h0000_0000) && ((lfsr & ~{21'h000000, span_mask}) == 32'h0000_0000);

   // requests that cannot be served are refused and flagged
   always_comb begin
      refuse = 1'b0;
      if (start) begin
         if (state != S_IDLE)
            refuse = 1'b1;
         else if ((new_cfg.mode == MODE_CORR || new_cfg.mode == MODE_SEARCH) && !new_cfg.poly32)
            refuse = 1'b1;   // RL2
         else if ((new_cfg.mode == MODE_TX || new_cfg.mode == MODE_RX) &&
                  (new_cfg.len_bytes == 11'h000 || int'(new_cfg.len_bytes) > MAXB))
            refuse = 1'b1;   // RL5
      end
   end

   // sequencer, check register and bit counters
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= S_IDLE;
         lfsr  <= 32'hffff_ffff;
         cnt   <= 14'h0000;
         ccnt  <= 6'h00;
      end else begin
         case (state)
            S_IDLE: begin
               if (start && !refuse) begin
                  cnt <= 14'h0000;
                  case (new_cfg.mode)   // RL6
                     MODE_TX, MODE_RX: begin
                        lfsr  <= new_cfg.poly32 ? MASK32 : MASK16;   // RL9
                        state <= S_DATA;
                     end
                     MODE_CORR: state <= S_TRAP;   // RL10
                     default:   state <= S_IDLE;
                  endcase
               end else if (step && cfg.mode == MODE_SEARCH && cfg.poly32) begin
                  lfsr <= next_lfsr;   // RL10
                  cnt  <= cnt + 14'h0001;
               end
            end
            S_DATA: if (take) begin
               lfsr <= lfsr_step(lfsr, in_bit, cfg.poly32, poly, wmask);   // RL11
               cnt  <= cnt + 14'h0001;
               if (cnt == blk_bits - 14'h0001) begin
                  state <= S_CHECK;
                  ccnt  <= cw - 6'h01;
               end
            end
            S_CHECK: if (take) begin
               // transmit shifts the remainder out, receive folds the checkbits in
               lfsr <= (cfg.mode == MODE_TX) ? ({lfsr[30:0], 1'b0} & wmask) : next_lfsr;   // RL11
               ccnt <= ccnt - 6'h01;
               if (ccnt == 6'h00) state <= S_IDLE;
            end
            S_TRAP: if (take) begin
               if (lfsr == 32'h0000_0000 || trapped || cnt == blk_bits + {8'h00, cw})
                  state <= S_IDLE;
               else begin
                  lfsr <= next_lfsr;   // RL10
                  cnt  <= cnt + 14'h0001;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // burst location and pattern from the hardware cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         loc     <= 14'h0000;
         pattern <= 11'h000;
      end else if (state == S_TRAP && take && trapped) begin
         loc     <= cnt;                        // RL4
         pattern <= lfsr[10:0] & span_mask;
      end
   end

   // serial transmit port, registered; the remainder leaves msb first
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         TX_BIT   <= 1'b0;
         TX_VALID <= 1'b0;
      end else if (cfg.mode == MODE_TX && state == S_DATA) begin
         TX_BIT   <= SRC_BIT;   // RL8
         TX_VALID <= take;
      end else if (cfg.mode == MODE_TX && state == S_CHECK) begin
         TX_BIT   <= (cfg.poly32 ? lfsr[31] : lfsr[15]) ^ inv_bit;   // RL11
         TX_VALID <= take;
      end else begin
         TX_BIT   <= 1'b0;
         TX_VALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // events and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      ev = '0;
      ev[STAT_DONE]    = last_chk || (state == S_TRAP && take &&
                         (lfsr == 32'h0000_0000 || trapped || cnt == blk_bits + {8'h00, cw}));
      ev[STAT_SYN]     = last_chk && cfg.mode == MODE_RX && next_lfsr != 32'h0000_0000;   // RL12
      ev[STAT_TRAP]    = state == S_TRAP && take && trapped;
      ev[STAT_UNCORR]  = state == S_TRAP && take && !trapped && lfsr != 32'h0000_0000 &&
                         cnt == blk_bits + {8'h00, cw};   // RL5
      ev[STAT_REFUSED] = refuse;
   end

   // sticky status, a new event wins over a write-one clear in the same cycle
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) status <= '0;
      else         status <= (status & ~clr) | ev;
   end

   assign IRQ  = |(status & irq_mask);
   assign BUSY = (state != S_IDLE);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_hold_freeze;
      @(posedge CLK) disable iff (!ARST_N)
      (HOLD && state != S_IDLE) |=> ($stable(lfsr) && $stable(cnt) && $stable(ccnt));
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("check state moved during hold"); // RL7

   property p_preset;
      @(posedge CLK) disable iff (!ARST_N)
      (start && !refuse && (new_cfg.mode == MODE_TX || new_cfg.mode == MODE_RX))
      |=> (state == S_DATA && lfsr == wmask && cnt == 14'h0000);
   endproperty
   a_preset: assert property (p_preset) else $error("check register not preset to ones"); // RL9

   property p_crc_no_correct;
      @(posedge CLK) disable iff (!ARST_N)
      (state == S_TRAP) |-> cfg.poly32;
   endproperty
   a_crc_no_correct: assert property (p_crc_no_correct) else $error("correction with 16-bit code"); // RL2

   property p_data_shift;
      @(posedge CLK) disable iff (!ARST_N)
      (state == S_DATA && take && !(cfg.poly32 ? lfsr[31] : lfsr[15]) && !in_bit)
      |=> (lfsr == (({$past(lfsr[30:0]), 1'b0}) & wmask));
   endproperty
   a_data_shift: assert property (p_data_shift) else $error("zero feedback step not a plain shift"); // RL11

   property p_feedback;
      @(posedge CLK) disable iff (!ARST_N)
      (state == S_DATA && take && ((cfg.poly32 ? lfsr[31] : lfsr[15]) ^ in_bit))
      |=> (lfsr == ((({$past(lfsr[30:0]), 1'b0}) ^ poly) & wmask));
   endproperty
   a_feedback: assert property (p_feedback) else $error("generator feedback wrong"); // RL1

   property p_tx_appends;
      @(posedge CLK) disable iff (!ARST_N)
      (cfg.mode == MODE_TX && state == S_DATA && take && cnt == blk_bits - 14'h0001)
      |=> (state == S_CHECK && ccnt == cw - 6'h01) ##1 (TX_VALID != $past(HOLD)) [*1];
   endproperty
   a_tx_appends: assert property (p_tx_appends) else $error("checkbits not appended"); // RL11

   property p_rx_port_quiet;
      @(posedge CLK) disable iff (!ARST_N)
      (cfg.mode != MODE_TX) |=> !TX_VALID;
   endproperty
   a_rx_port_quiet: assert property (p_rx_port_quiet) else $error("transmit port driven outside transmit"); // RL8

   property p_rx_error;
      @(posedge CLK) disable iff (!ARST_N)
      (last_chk && cfg.mode == MODE_RX && next_lfsr != 32'h0000_0000)
      |=> (status[STAT_SYN] && status[STAT_DONE] && state == S_IDLE && lfsr != 32'h0000_0000);
   endproperty
   a_rx_error: assert property (p_rx_error) else $error("nonzero syndrome not flagged"); // RL12

   property p_trap_span;
      @(posedge CLK) disable iff (!ARST_N)
      ev[STAT_TRAP] |=> (({21'h000000, pattern} & ~{21'h000000, span_mask}) == 32'h0000_0000
                         && loc == $past(cnt) && status[STAT_TRAP]);
   endproperty
   a_trap_span: assert property (p_trap_span) else $error("trapped burst wider than span"); // RL4

   property p_len_limit;
      @(posedge CLK) disable iff (!ARST_N)
      (start && state == S_IDLE && new_cfg.mode == MODE_RX && int'(new_cfg.len_bytes) > MAXB)
      |=> (state == S_IDLE && status[STAT_REFUSED]);
   endproperty
   a_len_limit: assert property (p_len_limit) else $error("oversize block accepted"); // RL5

   property p_set_wins;
      @(posedge CLK) disable iff (!ARST_N)
      (ev[STAT_DONE] && clr[STAT_DONE]) |=> status[STAT_DONE];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

   c_tx_block:  cover property (@(posedge CLK) disable iff (!ARST_N)
                                (cfg.mode == MODE_TX && last_chk));
   c_rx_error:  cover property (@(posedge CLK) disable iff (!ARST_N) ev[STAT_SYN]);
   c_trapped:   cover property (@(posedge CLK) disable iff (!ARST_N) ev[STAT_TRAP]);
   c_uncorr:    cover property (@(posedge CLK) disable iff (!ARST_N) ev[STAT_UNCORR]);

endmodule
`default_nettype wire

// ---- shared/burst_ecc_pkg.sv ----
// constants, field layouts and carrier types of the serial burst error recovery unit
//
// Summary of operation
// (RL1) The 16-bit check uses the CCITT generator with terms of degree 16, 12, 5 and 0.
// (RL2) With the 16-bit generator the unit only generates and checks, and never corrects.
// (RL3) The 32-bit generator, terms 32, 28, 26, 19, 17, 10, 6, 2 and 0, both generates and corrects.
// (RL4) With the 32-bit code a single burst of programmable span 5, 8 or 11 bits is corrected.
// (RL5) With the 32-bit code double bursts are detected, and a block holds at most 1024 data bytes.
// (RL6) Four modes exist, transmit, receive, correct and search, one chosen for each phase of a block.
// (RL7) While the idle input is high nothing advances and the check state is kept; a start or a search step written while idle still takes effect.
// (RL8) Received and transmitted serial data use separate ports that never share a path.
// (RL9) The check register is preset to all ones before a block, and checkbits can be inverted selectively.
// (RL10) Correction is by software from the exposed syndrome or by a hardware cycle that finds the burst.
// (RL11) One data bit per clock enters the feedback register, and in transmit the checkbits follow the data.
// (RL12) In receive a nonzero remaining syndrome after data and checkbits raises an error.
package burst_ecc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MASK   = 8'h08;
   localparam logic [7:0] OFF_SYND   = 8'h0c;
   localparam logic [7:0] OFF_INVERT = 8'h10;
   localparam logic [7:0] OFF_LOC    = 8'h14;
   localparam logic [7:0] OFF_STEP   = 8'h18;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_START   = 5;
   localparam int STAT_W       = 5;
   localparam int STAT_DONE    = 0;
   localparam int STAT_SYN     = 1;
   localparam int STAT_TRAP    = 2;
   localparam int STAT_UNCORR  = 3;
   localparam int STAT_REFUSED = 4;

   // ----------------------------------------------------------------
   // generators, spans and sizes
   // ----------------------------------------------------------------
   localparam logic [31:0] POLY16     = 32'h0000_1021;
   localparam logic [31:0] POLY32     = 32'h140a_0445;
   localparam logic [31:0] MASK16     = 32'h0000_ffff;
   localparam logic [31:0] MASK32     = 32'hffff_ffff;
   localparam logic [5:0]  CW16       = 6'h10;
   localparam logic [5:0]  CW32       = 6'h20;
   localparam logic [10:0] SPAN5_MASK  = 11'h01f;
   localparam logic [10:0] SPAN8_MASK  = 11'h0ff;
   localparam logic [10:0] SPAN11_MASK = 11'h7ff;
   localparam int          MAX_BYTES  = 1024;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0]       INVERT_RST = 32'h0000_0000;
   localparam logic [STAT_W-1:0] MASK_RST   = 5'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {MODE_TX, MODE_RX, MODE_CORR, MODE_SEARCH} mode_e;

   typedef struct packed {
      logic [10:0] len_bytes;
      logic [1:0]  span;
      logic        poly32;
      mode_e       mode;
   } ctrl_s;

   localparam ctrl_s CTRL_RST = '{len_bytes: 11'h000, span: 2'h0, poly32: 1'b0, mode: MODE_TX};

endpackage
